//--- logic/smv_map.svh
// register offsets, field positions, reset values and timing counts
// assumes a 10 MHz system clock and a byte-addressed 32-bit register bus
`ifndef SMV_MAP_SVH
`define SMV_MAP_SVH

// ==============================================
// clock
`define SMV_CLK_MHZ         10

// ==============================================
// register byte offsets
`define SMV_OFS_UV          8'h00
`define SMV_OFS_OV          8'h04
`define SMV_OFS_PRE_SAFE    8'h08
`define SMV_OFS_CORE_SAFE   8'h0C
`define SMV_OFS_CFG         8'h10
`define SMV_OFS_STATE       8'h14
`define SMV_OFS_IRQ_STAT    8'h18
`define SMV_OFS_IRQ_MASK    8'h1C

// ==============================================
// comparator index: which bit of the comparator vector is which rail
`define SMV_C_PRE_UV        0
`define SMV_C_PRE_OV        1
`define SMV_C_PRE_PROT      2
`define SMV_C_CORE_UV       3
`define SMV_C_CORE_OV       4
`define SMV_C_CORE_PROT     5
`define SMV_C_BAT_UV        6
`define SMV_C_BAT_OV        7

// ==============================================
// field positions
`define SMV_B_PRE           0
`define SMV_B_CORE          1
`define SMV_B_BAT           6
`define SMV_B_PROT          3
`define SMV_B_PRE_UV_RST    0
`define SMV_B_PRE_OV_RST    1
`define SMV_B_PRE_PROT_OFF  2
`define SMV_B_CORE_UV_RST   3
`define SMV_B_CORE_OV_RST   4
`define SMV_B_BAT_LOW_IRQ   5
`define SMV_B_GO_ACTIVE     8
`define SMV_B_ST_REQ        9
`define SMV_B_ST_BUSY       4
`define SMV_B_ST_FAIL       5
`define SMV_B_CORE_OFF      6
`define SMV_I_FAULT         0
`define SMV_I_ST_DONE       1
`define SMV_I_ST_FAIL       2

// ==============================================
// reset values
`define SMV_CFG_RST         6'h00
`define SMV_MASK_RST        3'h0

// ==============================================
// timing: least times round up to whole cycles
`define SMV_DGL_RAIL_NS     21000
`define SMV_DGL_BUV_NS      90000
`define SMV_DGL_BOV_NS      10000
`define SMV_CORE_OFF_NS     100000
`define SMV_ST_PHASE_NS     5000
`define SMV_CYC(ns)         (((ns) * `SMV_CLK_MHZ + 999) / 1000)
`define SMV_ST_PHASES       6
`define SMV_ST_MASK         8'h3F

`endif

//--- logic/smv_pkg.sv
// types shared by the supply monitor modules
// assumes nothing beyond the map header
package smv_pkg;
  typedef enum logic [2:0] {SMV_INIT, SMV_DIAG, SMV_ACTIVE, SMV_SAFE, SMV_RESET,
                            SMV_OFF} smv_state_t;
  // ordered by severity, weakest first
  typedef enum logic [1:0] {SMV_RX_NONE, SMV_RX_SAFE, SMV_RX_RESET, SMV_RX_OFF} smv_react_t;
endpackage : smv_pkg

//--- logic/smv_st_if.sv
// self-test handshake between the monitor core and the pattern checker
// assumes one clock for both ends
`timescale 1ns/1ps
interface smv_st_if;
  logic       start;
  logic       busy;
  logic       done;
  logic       fail;
  logic       pattern;
  logic [7:0] observe;
  modport check (input start, input observe, output busy, output done, output fail,
                 output pattern);
  modport owner (output start, output observe, input busy, input done, input fail,
                 input pattern);
endinterface : smv_st_if

//--- logic/smv_deglitch.sv
// per-comparator deglitch filter
// assumes the comparator level is already synchronous to clk_sys
`timescale 1ns/1ps
module smv_deglitch #(
  parameter int unsigned CYC = 210
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic nrst,
  // comparator in, filtered level out
  input  wire logic fault_i,
  output logic      level_o
);
  logic [9:0] cnt_ff;

  // count while the fault stands; any gap restarts the count
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      cnt_ff <= 10'h000;
    else if (!fault_i)
      cnt_ff <= 10'h000;
    else if (cnt_ff != 10'(CYC - 1))
      cnt_ff <= cnt_ff + 10'h001;
  end

  // level drops at once: clearing only needs the fault to be gone
  assign level_o = fault_i && (cnt_ff == 10'(CYC - 1));
endmodule : smv_deglitch

//--- logic/smv_self_test.sv
// comparator self-test sequencer and toggle pattern checker
// assumes the analog side forces every tested comparator to the pattern level
`timescale 1ns/1ps
`include "smv_map.svh"
module smv_self_test
  import smv_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // handshake with the monitor core
  smv_st_if.check st
);
  localparam int unsigned PHASE_CYC = `SMV_CYC(`SMV_ST_PHASE_NS);
  logic [2:0] phase_ff;
  logic [5:0] cnt_ff;
  logic       busy_ff;
  logic       bad_ff;
  logic       done_ff;
  logic       fail_ff;
  logic       last_cyc;
  logic       mismatch;

  assign last_cyc = busy_ff && (cnt_ff == 6'(PHASE_CYC - 1));
  // compare at the end of each phase so the comparators have settled
  assign mismatch = |((st.observe ^ {8{st.pattern}}) & `SMV_ST_MASK);

  // sequencer: phases alternate the forced level, several toggles per run
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      busy_ff  <= 1'b0;
      phase_ff <= 3'h0;
      cnt_ff   <= 6'h00;
    end
    else if (!busy_ff)
    begin
      busy_ff  <= st.start;
      phase_ff <= 3'h0;
      cnt_ff   <= 6'h00;
    end
    else if (last_cyc)
    begin
      cnt_ff   <= 6'h00;
      phase_ff <= phase_ff + 3'h1;
      busy_ff  <= (phase_ff != 3'(`SMV_ST_PHASES - 1));
    end
    else
      cnt_ff <= cnt_ff + 6'h01;
  end

  // verdict: any mismatch in the run fails it
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      bad_ff  <= 1'b0;
      done_ff <= 1'b0;
      fail_ff <= 1'b0;
    end
    else
    begin
      done_ff <= last_cyc && (phase_ff == 3'(`SMV_ST_PHASES - 1));
      if (!busy_ff)
        bad_ff <= 1'b0;
      else if (last_cyc && mismatch)
        bad_ff <= 1'b1;
      if (last_cyc && (phase_ff == 3'(`SMV_ST_PHASES - 1)))
        fail_ff <= bad_ff || mismatch;
    end
  end

  assign st.busy    = busy_ff;
  assign st.pattern = ~phase_ff[0];
  assign st.done    = done_ff;
  assign st.fail    = fail_ff;
endmodule : smv_self_test

//--- logic/smv_top.sv
// supply monitor event logic: sticky rail flags, fail-safe reaction,
// reset and interrupt outputs, self-test control, Avalon-MM registers
// assumes comparator and ramp levels synchronous to clk_sys
// How it works
// - each rail has own undervoltage, overvoltage flag, pre and core also a protection flag, readable over the bus
// - flags held at zero while their rail ramps up
// - flag set to one when rail leaves its window
// - set flag stays until read while its fault is gone
// - per-comparator deglitch timer; shorter faults set nothing
// - monitoring runs in every state, also with regulator off
// - self-test at power-up and on request in diagnostic, active, safe
// - self-test toggles comparators repeatedly and checks the pattern
// - self-test disturbs no rail and sets no flag or event
// - battery overvoltage sets overvoltage bit 6, goes off, reset and interrupt low
// - pre-regulator undervoltage: bit 0, reset or safe by enable, interrupt low
// - pre-regulator overvoltage: bit 0, safe or reset by enable, interrupt low
// - pre-regulator protection: safety bit 3, off or safe by enable
// - core undervoltage: bit 1, reset if enabled else no state change
// - core overvoltage: bit 1, safe or reset by enable, interrupt low
// - core protection persisting off-delay after disable goes off
// - combined enable/interrupt output is active low on fault events
//
// Our own choices: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`include "smv_map.svh"
module smv_top
  import smv_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  // register bus
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // analog comparators and ramp status
  input  wire logic [7:0]  cmp_fault,
  input  wire logic [2:0]  rail_ramping,
  output logic             st_force,
  output logic             st_pattern,
  output logic             corereg_disable,
  // system side
  output smv_state_t       op_state,
  output logic             reset_out_n,
  output logic             enable_irq_out_n,
  output logic             irq
);
  // ==============================================
  // bus slave
  logic        ack_ff;
  logic [31:0] rdata_ff;
  logic        rd_acc;
  logic        wr_acc;
  logic [31:0] rd_mux;
  logic [15:0] wdat;

  // one wait state: data is registered in the first cycle
  assign avs_waitrequest = (avs_read || avs_write) && !ack_ff;
  assign rd_acc          = avs_read && ack_ff;
  assign wr_acc          = avs_write && ack_ff;
  assign wdat = avs_writedata[15:0] & {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      ack_ff <= 1'b0;
    else
      ack_ff <= (avs_read || avs_write) && !ack_ff;
  end

  // ==============================================
  // comparator filtering
  localparam int unsigned DGL_RAIL = `SMV_CYC(`SMV_DGL_RAIL_NS);
  localparam int unsigned DGL_BUV  = `SMV_CYC(`SMV_DGL_BUV_NS);
  localparam int unsigned DGL_BOV  = `SMV_CYC(`SMV_DGL_BOV_NS);
  localparam int unsigned DGL_CYC [8] = '{DGL_RAIL, DGL_RAIL, DGL_RAIL, DGL_RAIL,
                                           DGL_RAIL, DGL_RAIL, DGL_BUV, DGL_BOV};
  smv_st_if    st_bus ();
  logic [7:0]  cmp_live;
  logic [7:0]  filt;
  logic [7:0]  ramp8;
  logic [7:0]  fault;
  logic [7:0]  fault_prev_ff;
  logic [7:0]  evt;

  // while the checker forces the comparators nothing reaches the filters
  assign cmp_live       = cmp_fault & {8{!st_bus.busy}};
  assign st_bus.observe = cmp_fault;
  assign ramp8          = {{2{rail_ramping[2]}}, {3{rail_ramping[1]}}, {3{rail_ramping[0]}}};

  // no state gates the filters, so a rail is watched even when switched off
  for (genvar i = 0; i < 8; i++)
  begin : g_dgl
    smv_deglitch #(.CYC(DGL_CYC[i])) u_dgl (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .fault_i (cmp_live[i]),
      .level_o (filt[i])
    );
  end

  assign fault = filt & ~ramp8;
  assign evt   = fault & ~fault_prev_ff;

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      fault_prev_ff <= 8'h00;
    else
      fault_prev_ff <= fault;
  end

  // ==============================================
  // sticky rail flags
  logic [7:0] flag_ff;
  logic [7:0] rd_sel;

  // a read clears only the flags of that register whose fault is gone
  always_comb
  begin
    rd_sel = 8'h00;
    if (!rd_acc)
      rd_sel = 8'h00;
    else if (avs_address == `SMV_OFS_UV)
      rd_sel = 8'h49;
    else if (avs_address == `SMV_OFS_OV)
      rd_sel = 8'h92;
    else if (avs_address == `SMV_OFS_PRE_SAFE)
      rd_sel = 8'h04;
    else if (avs_address == `SMV_OFS_CORE_SAFE)
      rd_sel = 8'h20;
  end

  // set wins over the read clear: an active fault is never lost
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      flag_ff <= 8'h00;
    else
      flag_ff <= ((flag_ff & ~(rd_sel & ~fault)) | fault) & ~ramp8;
  end

  // ==============================================
  // configuration
  logic [5:0] cfg_ff;
  logic       go_active;
  logic       st_req;

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      cfg_ff <= `SMV_CFG_RST;
    else if (wr_acc && (avs_address == `SMV_OFS_CFG))
      cfg_ff <= wdat[5:0];
  end

  assign go_active = wr_acc && (avs_address == `SMV_OFS_CFG) && wdat[`SMV_B_GO_ACTIVE];
  assign st_req    = wr_acc && (avs_address == `SMV_OFS_CFG) && wdat[`SMV_B_ST_REQ];

  // ==============================================
  // reaction per event and severity merge
  smv_react_t rx_pre_uv;
  smv_react_t rx_pre_ov;
  smv_react_t rx_pre_prot;
  smv_react_t rx_core_uv;
  smv_react_t rx_core_ov;
  smv_react_t react;
  logic       irq_evt;

  // each reaction holds for as long as its fault stands
  always_comb
  begin
    rx_pre_uv   = cfg_ff[`SMV_B_PRE_UV_RST] ? SMV_RX_RESET : SMV_RX_SAFE;
    rx_pre_ov   = cfg_ff[`SMV_B_PRE_OV_RST] ? SMV_RX_RESET : SMV_RX_SAFE;
    rx_pre_prot = cfg_ff[`SMV_B_PRE_PROT_OFF] ? SMV_RX_OFF : SMV_RX_SAFE;
    rx_core_uv  = cfg_ff[`SMV_B_CORE_UV_RST] ? SMV_RX_RESET : SMV_RX_NONE;
    rx_core_ov  = cfg_ff[`SMV_B_CORE_OV_RST] ? SMV_RX_RESET : SMV_RX_SAFE;
    react = SMV_RX_NONE;
    // strongest wins regardless of which fault arrived first
    if (fault[`SMV_C_BAT_OV]
        || (fault[`SMV_C_PRE_PROT] && (rx_pre_prot == SMV_RX_OFF)))
      react = SMV_RX_OFF;
    else if ((fault[`SMV_C_PRE_UV] && (rx_pre_uv == SMV_RX_RESET))
             || (fault[`SMV_C_PRE_OV] && (rx_pre_ov == SMV_RX_RESET))
             || (fault[`SMV_C_CORE_UV] && (rx_core_uv == SMV_RX_RESET))
             || (fault[`SMV_C_CORE_OV] && (rx_core_ov == SMV_RX_RESET)))
      react = SMV_RX_RESET;
    else if (fault[`SMV_C_PRE_UV] || fault[`SMV_C_PRE_OV] || fault[`SMV_C_PRE_PROT]
             || fault[`SMV_C_CORE_OV] || fault[`SMV_C_CORE_PROT])
      react = SMV_RX_SAFE;
  end

  // battery low only interrupts when enabled; every other event does
  assign irq_evt = |(evt & 8'hBF)
                   || (evt[`SMV_C_BAT_UV] && cfg_ff[`SMV_B_BAT_LOW_IRQ]);

  // ==============================================
  // core regulator protection off-delay
  localparam int unsigned CORE_OFF_CYC = `SMV_CYC(`SMV_CORE_OFF_NS);
  logic        core_off_ff;
  logic [10:0] off_cnt_ff;
  logic        off_timeout;

  // the regulator stays disabled until software writes the go-active bit once the protection fault is gone
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      core_off_ff <= 1'b0;
    else if (fault[`SMV_C_CORE_PROT])
      core_off_ff <= 1'b1;
    else if (go_active)
      core_off_ff <= 1'b0;
  end

  // count only while disabled and the protection fault persists
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      off_cnt_ff <= 11'h000;
    else if (!(core_off_ff && fault[`SMV_C_CORE_PROT]))
      off_cnt_ff <= 11'h000;
    else if (!off_timeout)
      off_cnt_ff <= off_cnt_ff + 11'h001;
  end

  assign off_timeout     = (off_cnt_ff == 11'(CORE_OFF_CYC));
  assign corereg_disable = core_off_ff;

  // ==============================================
  // operating state
  smv_state_t state_ff;
  smv_state_t nxt_state;
  logic       st_ok_state;

  assign st_ok_state = (state_ff == SMV_DIAG) || (state_ff == SMV_ACTIVE)
                       || (state_ff == SMV_SAFE);

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      SMV_INIT:
        if (st_bus.done)
          nxt_state = SMV_DIAG;
      SMV_DIAG, SMV_ACTIVE, SMV_SAFE:
        if ((react == SMV_RX_OFF) || off_timeout)
          nxt_state = SMV_OFF;
        else if (react == SMV_RX_RESET)
          nxt_state = SMV_RESET;
        else if (react == SMV_RX_SAFE)
          nxt_state = SMV_SAFE;
        else if (go_active)
          nxt_state = SMV_ACTIVE;
      SMV_RESET:
        if ((react == SMV_RX_OFF) || off_timeout)
          nxt_state = SMV_OFF;
        else if (react != SMV_RX_RESET)
          nxt_state = SMV_DIAG;
      SMV_OFF:
        nxt_state = SMV_OFF; // left only by a power-up reset
      default:
        nxt_state = SMV_OFF;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      state_ff <= SMV_INIT;
    else
      state_ff <= nxt_state;
  end

  // reset output low in init, reset and off; registered to avoid glitches
  logic nrst_out_ff;
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      nrst_out_ff <= 1'b0;
    else
      nrst_out_ff <= (nxt_state != SMV_INIT) && (nxt_state != SMV_RESET)
                     && (nxt_state != SMV_OFF);
  end

  assign op_state    = state_ff;
  assign reset_out_n = nrst_out_ff;

  // ==============================================
  // self-test control
  logic st_boot_ff;
  logic st_fail_ff;

  // power-up run starts once after reset release
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      st_boot_ff <= 1'b1;
    else
      st_boot_ff <= 1'b0;
  end

  assign st_bus.start = st_boot_ff || (st_req && st_ok_state);
  assign st_force     = st_bus.busy;
  assign st_pattern   = st_bus.pattern;

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      st_fail_ff <= 1'b0;
    else if (st_bus.done)
      st_fail_ff <= st_bus.fail;
  end

  smv_self_test u_st (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .st      (st_bus.check)
  );

  // ==============================================
  // interrupt status and mask
  logic [2:0] irq_stat_ff;
  logic [2:0] irq_mask_ff;
  logic [2:0] irq_set;
  logic [2:0] irq_clr;

  assign irq_set = {st_bus.done && st_bus.fail, st_bus.done, irq_evt};
  assign irq_clr = (wr_acc && (avs_address == `SMV_OFS_IRQ_STAT)) ? wdat[2:0] : 3'h0;

  // set beats a same-cycle write-one clear
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      irq_stat_ff <= 3'h0;
    else
      irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      irq_mask_ff <= `SMV_MASK_RST;
    else if (wr_acc && (avs_address == `SMV_OFS_IRQ_MASK))
      irq_mask_ff <= wdat[2:0];
  end

  assign irq              = |(irq_stat_ff & irq_mask_ff);
  assign enable_irq_out_n = !irq_stat_ff[`SMV_I_FAULT];

  // ==============================================
  // read data
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (avs_address == `SMV_OFS_UV)
    begin
      rd_mux[`SMV_B_PRE]  = flag_ff[`SMV_C_PRE_UV];
      rd_mux[`SMV_B_CORE] = flag_ff[`SMV_C_CORE_UV];
      rd_mux[`SMV_B_BAT]  = flag_ff[`SMV_C_BAT_UV];
    end
    else if (avs_address == `SMV_OFS_OV)
    begin
      rd_mux[`SMV_B_PRE]  = flag_ff[`SMV_C_PRE_OV];
      rd_mux[`SMV_B_CORE] = flag_ff[`SMV_C_CORE_OV];
      rd_mux[`SMV_B_BAT]  = flag_ff[`SMV_C_BAT_OV];
    end
    else if (avs_address == `SMV_OFS_PRE_SAFE)
      rd_mux[`SMV_B_PROT] = flag_ff[`SMV_C_PRE_PROT];
    else if (avs_address == `SMV_OFS_CORE_SAFE)
      rd_mux[`SMV_B_PROT] = flag_ff[`SMV_C_CORE_PROT];
    else if (avs_address == `SMV_OFS_CFG)
      rd_mux[5:0] = cfg_ff;
    else if (avs_address == `SMV_OFS_STATE)
    begin
      rd_mux[2:0]              = state_ff;
      rd_mux[`SMV_B_ST_BUSY]   = st_bus.busy;
      rd_mux[`SMV_B_ST_FAIL]   = st_fail_ff;
      rd_mux[`SMV_B_CORE_OFF]  = core_off_ff;
    end
    else if (avs_address == `SMV_OFS_IRQ_STAT)
      rd_mux[2:0] = irq_stat_ff;
    else if (avs_address == `SMV_OFS_IRQ_MASK)
      rd_mux[2:0] = irq_mask_ff;
  end

  // captured in the wait cycle, stands while waitrequest is low
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      rdata_ff <= 32'h0000_0000;
    else if (avs_read && !ack_ff)
      rdata_ff <= rd_mux;
  end

  assign avs_readdata = rdata_ff;
endmodule : smv_top

//--- verif/smv_top_asserts.sv
// concurrent checks on the supply monitor top ports
// assumes a single clk_sys domain; bound in at the foot of this file
`timescale 1ns/1ps
module smv_top_asserts
  import smv_pkg::*;
(
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       nrst,
  // bus handshake
  input wire logic       avs_read,
  input wire logic       avs_write,
  input wire logic       avs_waitrequest,
  // monitor outputs
  input wire logic       st_force,
  input wire smv_state_t op_state,
  input wire logic       reset_out_n,
  input wire logic       enable_irq_out_n
);
  // =====
  // one domain, so clock and reset are given once
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  AST_OFF_RESET_LOW: assert property ((op_state == SMV_OFF) [*2] |-> !reset_out_n)
    else $error("reset output high while off");
  AST_SAFE_RESET_HIGH: assert property ((op_state == SMV_SAFE) [*2] |-> reset_out_n)
    else $error("reset output low while safe");
  AST_RST_STATE_LOW: assert property ((op_state == SMV_RESET) [*2] |-> !reset_out_n)
    else $error("reset output high in reset state");
  AST_RST_WITH_IRQ: assert property ($fell(reset_out_n) |-> ##[0:2] !enable_irq_out_n)
    else $error("reset dropped without interrupt");
  // forced comparators must not leak into events or state
  AST_ST_NO_IRQ: assert property ((st_force && !avs_write) [*2] |-> $stable(enable_irq_out_n))
    else $error("interrupt moved during self-test");
  AST_ST_NO_STATE: assert property (st_force && $past(st_force) |-> $stable(op_state))
    else $error("state moved during self-test");
  AST_PWRUP_ST: assert property ($rose(nrst) |-> ##[1:2] st_force)
    else $error("no self-test after reset release");
  AST_ST_LENGTH: assert property ($rose(st_force) |-> ##[290:310] !st_force)
    else $error("self-test length wrong");
  // exactly one wait cycle per access
  AST_RD_WAIT: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("read wait cycles wrong");
  AST_WR_WAIT: assert property ($rose(avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("write wait cycles wrong");
endmodule : smv_top_asserts

bind smv_top smv_top_asserts u_smv_top_asserts (.clk_sys(clk_sys), .nrst(nrst),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .st_force(st_force), .op_state(op_state), .reset_out_n(reset_out_n),
  .enable_irq_out_n(enable_irq_out_n));

//--- verif/smv_rail_model.sv
// analog comparator side: rail faults plus self-test forcing
// assumes the bench injects faults on inj and sets bad to break comparator 0
`timescale 1ns/1ps
module smv_rail_model
(
  // self-test forcing from the monitor
  input  wire logic       st_force,
  input  wire logic       st_pattern,
  // bench controls
  input  wire logic [7:0] inj,
  input  wire logic       bad,
  // comparator levels
  output logic      [7:0] cmp_fault
);
  // =====
  // battery comparators are never forced; bad flips comparator 0
  always_comb
  begin
    cmp_fault = inj;
    if (st_force)
      cmp_fault[5:0] = {6{st_pattern}} ^ {5'h00, bad};
  end
endmodule : smv_rail_model

//--- verif/smv_top_tb.sv
// self-checking bench for the supply monitor event logic
// assumes the rail model on the comparators and the bound checker
`timescale 1ns/1ps
`include "smv_map.svh"
`define CHK(nm, e, s) begin tests_run++; if ((s) !== (e)) begin error_cnt++; \
  $display("unexpected %s exp %0h got %0h", nm, e, s); end end
module smv_top_tb
  import smv_pkg::*;
;
  logic        clk_sys, nrst, avs_read, avs_write, avs_waitrequest, bad;
  logic [7:0]  avs_address, inj, cmp_fault;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [2:0]  rail_ramping;
  logic        st_force, st_pattern, corereg_disable, reset_out_n, enable_irq_out_n, irq;
  smv_state_t  op_state, st;
  logic [5:0]  cfg;
  logic [5:0]  rnd [8];
  int          error_cnt, tests_run, cyc, dg;

  smv_top u_smv_top (.clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .cmp_fault(cmp_fault), .rail_ramping(rail_ramping), .st_force(st_force),
    .st_pattern(st_pattern), .corereg_disable(corereg_disable), .op_state(op_state),
    .reset_out_n(reset_out_n), .enable_irq_out_n(enable_irq_out_n), .irq(irq));
  smv_rail_model u_smv_rail_model (.st_force(st_force), .st_pattern(st_pattern),
    .inj(inj), .bad(bad), .cmp_fault(cmp_fault));

  // =====
  // 10 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // hang guard, well above the ~25k cycles the run needs
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      error_cnt++;
      final_report;
    end
  end

  // =====
  // expected reaction per comparator index
  function automatic smv_state_t exp_st(int i, logic [5:0] c);
    case (i)
      0: return c[0] ? SMV_RESET : SMV_SAFE;
      1: return c[1] ? SMV_RESET : SMV_SAFE;
      2: return c[2] ? SMV_OFF : SMV_SAFE;
      3: return c[3] ? SMV_RESET : SMV_ACTIVE;
      4: return c[4] ? SMV_RESET : SMV_SAFE;
      6: return SMV_ACTIVE;
      7: return SMV_OFF;
      default: return SMV_SAFE;
    endcase
  endfunction : exp_st

  // flag register and bit per comparator index
  function automatic logic [7:0] fofs(int i);
    return (i == 2) ? `SMV_OFS_PRE_SAFE : (i == 5) ? `SMV_OFS_CORE_SAFE :
           (i % 3 == 0) ? `SMV_OFS_UV : `SMV_OFS_OV;
  endfunction : fofs

  function automatic logic [7:0] fbit(int i);
    return 8'h01 << ((i == 2 || i == 5) ? 3 : (i < 2) ? 0 : (i < 5) ? 1 : 6);
  endfunction : fbit

  // one bus cycle, held until waitrequest is sampled low
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= we;
    avs_read      <= !we;
    do
      @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask : bus

  task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    bus(1'b0, a, 32'h0000_0000);
    `CHK("readdata", e, q[7:0] & m)
  endtask : rchk

  // reset always ends after the power-up self-test
  task automatic do_reset;
    nrst <= 1'b0;
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (320) @(posedge clk_sys);
  endtask : do_reset

  task automatic final_report;
    if (error_cnt == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report

  // =====
  initial
  begin
    nrst = 1'b0; avs_read = 1'b0; avs_write = 1'b0; avs_address = 8'h00;
    avs_writedata = 32'h0000_0000; inj = 8'h00; rail_ramping = 3'h0; bad = 1'b0;
    void'($urandom(32'hc48e_7bb4));
    do_reset;
    `CHK("op_state", SMV_DIAG, op_state)
    `CHK("reset_out_n", 1'b1, reset_out_n)
    rchk(8'h1C, 8'h07, 8'h00);
    bus(1'b1, 8'h40, 32'hFFFF_FFFF);
    rchk(8'h40, 8'hFF, 8'h00);
    // interrupt: mask, clear, then done and fail events
    bus(1'b1, 8'h1C, 32'h0000_0007);
    `CHK("irq", 1'b1, irq)
    bus(1'b1, 8'h18, 32'h0000_0007);
    bus(1'b1, 8'h1C, 32'h0000_0000);
    rchk(8'h18, 8'h07, 8'h00);
    for (int b = 0; b < 2; b++)
    begin
      bad <= b[0];
      bus(1'b1, 8'h10, 32'h0000_0200);
      repeat (320) @(posedge clk_sys);
      rchk(8'h14, 8'h30, {2'h0, b[0], 5'h00});
      rchk(8'h18, 8'h07, {5'h00, b[0], 2'b10});
      `CHK("irq", 1'b0, irq)
      bus(1'b1, 8'h1C, 32'h0000_0006);
      `CHK("irq", 1'b1, irq)
      bus(1'b1, 8'h1C, 32'h0000_0000);
      rchk(`SMV_OFS_UV, 8'h43, 8'h00);
      bus(1'b1, 8'h18, 32'h0000_0007);
    end
    bad <= 1'b0;
    // faults while ramping leave no trace; the filter drains before release
    rail_ramping <= 3'b111;
    inj[1] <= 1'b1;
    repeat (240) @(posedge clk_sys);
    `CHK("op_state", SMV_DIAG, op_state)
    inj[1] <= 1'b0;
    repeat (240) @(posedge clk_sys);
    rail_ramping <= 3'b000;
    rchk(`SMV_OFS_OV, 8'h43, 8'h00);
    // every comparator, both values of every enable over two passes
    for (int p = 0; p < 2; p++)
      for (int i = 0; i < 8; i++)
      begin
        do_reset;
        if (p == 0)
          rnd[i] = 6'($urandom);
        cfg = rnd[i] ^ {6{p[0]}};
        bus(1'b1, 8'h10, {23'h0, 1'b1, 2'h0, cfg});
        `CHK("op_state", SMV_ACTIVE, op_state)
        dg = (i == 6) ? 900 : (i == 7) ? 100 : 210;
        inj[i] <= 1'b1;
        repeat (dg - 30) @(posedge clk_sys);
        inj[i] <= 1'b0;
        repeat (40) @(posedge clk_sys);
        `CHK("op_state", SMV_ACTIVE, op_state)
        inj[i] <= 1'b1;
        repeat (dg + 20) @(posedge clk_sys);
        st = exp_st(i, cfg);
        `CHK("op_state", st, op_state)
        `CHK("reset_out_n", !(st inside {SMV_RESET, SMV_OFF}), reset_out_n)
        `CHK("enable_irq_out_n", (i == 6) && !cfg[5], enable_irq_out_n)
        if (i == 5)
        begin
          `CHK("corereg_disable", 1'b1, corereg_disable)
          repeat (1010) @(posedge clk_sys);
          `CHK("op_state", SMV_OFF, op_state)
        end
        rchk(fofs(i), fbit(i), fbit(i));
        inj[i] <= 1'b0;
        repeat (dg + 20) @(posedge clk_sys);
        rchk(fofs(i), fbit(i), fbit(i));
        rchk(fofs(i), fbit(i), 8'h00);
      end
    final_report;
  end
endmodule : smv_top_tb
